//--- rtl/dsp_regfile_map.vh
// Constants for the DSP data registers and condition status word
`ifndef DSP_REGFILE_MAP_VH
`define DSP_REGFILE_MAP_VH

// ----------------------------------------
// Widths
// ----------------------------------------
`define BODY_W 32
`define GUARD_W 8
`define ACC_W 40
`define STATUS_STORED_W 8

// ----------------------------------------
// Status word layout and reset
// ----------------------------------------
`define STATUS_RESET 8'h00
`define STATUS_GREATER_BIT 7
`define STATUS_ZERO_BIT 6
`define STATUS_NEG_BIT 5
`define STATUS_OVF_BIT 4
`define STATUS_CSEL_HI 3
`define STATUS_CSEL_LO 1
`define STATUS_COND_BIT 0

// ----------------------------------------
// Condition select codes
// ----------------------------------------
`define CSEL_CARRY 3'h0
`define CSEL_NEGATIVE 3'h1
`define CSEL_ZERO 3'h2
`define CSEL_OVERFLOW 3'h3
`define CSEL_GREATER 3'h4
`define CSEL_ABOVE 3'h5

// ----------------------------------------
// Data register selectors
// ----------------------------------------
`define REG_ACCUM_FIRST 3'h0
`define REG_ACCUM_SECOND 3'h1
`define REG_MULT_IN_FIRST 3'h2
`define REG_MULT_IN_SECOND 3'h3
`define REG_XBUS_FIRST 3'h4
`define REG_XBUS_SECOND 3'h5
`define REG_YBUS_FIRST 3'h6
`define REG_YBUS_SECOND 3'h7

// ----------------------------------------
// System register selectors
// ----------------------------------------
`define SYS_STATUS 3'h0
`define SYS_ACCUM_FIRST 3'h1
`define SYS_XBUS_FIRST 3'h2
`define SYS_XBUS_SECOND 3'h3
`define SYS_YBUS_FIRST 3'h4
`define SYS_YBUS_SECOND 3'h5

// ----------------------------------------
// Operation codes
// ----------------------------------------
`define OP_ADD 4'h0
`define OP_SUB 4'h1
`define OP_CMP 4'h2
`define OP_COPY 4'h3
`define OP_AND 4'h4
`define OP_OR 4'h5
`define OP_XOR 4'h6
`define OP_CLEAR 4'h7
`define OP_PAR_MUL 4'h8
`define OP_XMEM_LOAD 4'h9
`define OP_YMEM_LOAD 4'hA
`define OP_SINGLE_WORD 4'hB
`define OP_SINGLE_LONG 4'hC
`define OP_SINGLE_GUARD 4'hD

`endif

//--- rtl/dsp_flag_unit.v
// Result flag and condition bit evaluation
`timescale 1ns/10ps
module dsp_flag_unit (
	input wire [39:0] result,
	input wire carry,
	input wire logic_mode,
	input wire [2:0] cond_select,
	output wire greater,
	output wire zero,
	output wire negative,
	output wire overflow,
	output reg cond_out
);
`include "dsp_regfile_map.vh"

	// ----------------------------------------
	// Flags
	// ----------------------------------------
	// Zero detect
	assign zero = logic_mode ? ~(|result[31:16]) : ~(|result);
	assign negative = logic_mode ? result[31] : result[39];
	assign overflow = logic_mode ? 1'b0 : ~((&result[39:31]) | ~(|result[39:31]));
	assign greater = ~negative & ~zero;

	// ----------------------------------------
	// Condition select
	// ----------------------------------------
	// Selected condition holds
	always @* begin
		case (cond_select)
			`CSEL_CARRY: cond_out = carry;
			`CSEL_NEGATIVE: cond_out = negative;
			`CSEL_ZERO: cond_out = zero;
			`CSEL_OVERFLOW: cond_out = overflow;
			`CSEL_GREATER: cond_out = greater;
			`CSEL_ABOVE: cond_out = ~negative;
			default: cond_out = 1'b0;
		endcase
	end

endmodule

//--- rtl/dsp_register_file_status.v
// DSP data register file with condition status word
`timescale 1ns/10ps
module dsp_register_file_status (
	input wire core_clk,
	input wire reset_n,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire [2:0] op_src1,
	input wire [2:0] op_src2,
	input wire [2:0] op_dst,
	input wire op_conditional,
	input wire op_exec_on_true,
	input wire [31:0] op_data,
	input wire sys_wr_en,
	input wire [2:0] sys_wr_sel,
	input wire [31:0] sys_wr_data,
	input wire [2:0] sys_rd_sel,
	output reg [31:0] sys_rd_data,
	output wire [31:0] status_word,
	output wire cond_bit,
	output reg op_done,
	output reg op_skipped
);
`include "dsp_regfile_map.vh"

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	// Accumulators and operands
	reg [31:0] accum_body [0:1];
	reg [7:0] accum_guard [0:1];
	reg [31:0] opnd_reg [0:5];
	reg [7:0] status_reg;
	reg [7:0] status_next;

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	function [2:0] opnd_index;
		input [2:0] sel;
		begin
			opnd_index = sel - 3'h2;
		end
	endfunction

	function [39:0] sign_ext;
		input [31:0] value;
		begin
			sign_ext = {{8{value[31]}}, value};
		end
	endfunction

	function is_accum;
		input [2:0] sel;
		begin
			is_accum = (sel[2:1] == 2'h0);
		end
	endfunction

	function [39:0] read_source;
		input [2:0] sel;
		begin
			if (is_accum(sel)) begin
				read_source = {accum_guard[sel[0]], accum_body[sel[0]]};
			end else begin
				read_source = sign_ext(opnd_reg[opnd_index(sel)]);
			end
		end
	endfunction

	// ----------------------------------------
	// Data path
	// ----------------------------------------
	wire [39:0] src1;
	wire [39:0] src2;
	wire [40:0] sum_wide;
	wire [40:0] diff_wide;
	wire signed [31:0] product;
	wire [15:0] logic_and;
	wire [15:0] logic_or;
	wire [15:0] logic_xor;

	assign src1 = read_source(op_src1);
	assign src2 = read_source(op_src2);
	assign sum_wide = {1'b0, src1} + {1'b0, src2};
	assign diff_wide = {1'b0, src1} - {1'b0, src2};
	assign product = $signed(src1[31:16]) * $signed(src2[31:16]);
	assign logic_and = src1[31:16] & src2[31:16];
	assign logic_or = src1[31:16] | src2[31:16];
	assign logic_xor = src1[31:16] ^ src2[31:16];

	// ----------------------------------------
	// Operation decode
	// ----------------------------------------
	reg [39:0] alu_result;
	reg alu_carry;
	reg logic_mode;
	reg flag_op;
	reg dp_write;
	reg guard_only;
	reg [2:0] dst_sel;

	always @* begin
		alu_result = 40'h00_0000_0000;
		alu_carry = 1'b0;
		logic_mode = 1'b0;
		flag_op = 1'b0;
		dp_write = 1'b0;
		guard_only = 1'b0;
		dst_sel = op_dst;
		case (op_code)
			`OP_ADD: begin
				alu_result = sum_wide[39:0];
				alu_carry = sum_wide[40];
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_SUB: begin
				alu_result = diff_wide[39:0];
				alu_carry = diff_wide[40];
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_CMP: begin
				alu_result = diff_wide[39:0];
				alu_carry = diff_wide[40];
				flag_op = 1'b1;
			end
			`OP_COPY: begin
				alu_result = src1;
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_AND: begin
				alu_result = {8'h00, logic_and, 16'h0000};
				logic_mode = 1'b1;
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_OR: begin
				alu_result = {8'h00, logic_or, 16'h0000};
				logic_mode = 1'b1;
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_XOR: begin
				alu_result = {8'h00, logic_xor, 16'h0000};
				logic_mode = 1'b1;
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_CLEAR: begin
				flag_op = 1'b1;
				dp_write = 1'b1;
			end
			`OP_PAR_MUL: begin
				alu_result = sign_ext({product[30:0], 1'b0});
				dp_write = 1'b1;
			end
			`OP_XMEM_LOAD: begin
				alu_result = sign_ext({op_data[15:0], 16'h0000});
				dst_sel = {2'h2, op_dst[0]};
				dp_write = 1'b1;
			end
			`OP_YMEM_LOAD: begin
				alu_result = sign_ext({op_data[15:0], 16'h0000});
				dst_sel = {2'h3, op_dst[0]};
				dp_write = 1'b1;
			end
			`OP_SINGLE_WORD: begin
				alu_result = sign_ext({op_data[15:0], 16'h0000});
				dp_write = 1'b1;
			end
			`OP_SINGLE_LONG: begin
				alu_result = sign_ext(op_data);
				dp_write = 1'b1;
			end
			`OP_SINGLE_GUARD: begin
				alu_result = {32'h0000_0000, op_data[7:0]};
				dst_sel = {2'h0, op_dst[0]};
				guard_only = 1'b1;
				dp_write = 1'b1;
			end
			default: begin
				dp_write = 1'b0;
			end
		endcase
	end

	// ----------------------------------------
	// Flag evaluation
	// ----------------------------------------
	wire flag_greater;
	wire flag_zero;
	wire flag_negative;
	wire flag_overflow;
	wire flag_cond;

	dsp_flag_unit flags (
		.result(alu_result),
		.carry(alu_carry),
		.logic_mode(logic_mode),
		.cond_select(status_reg[`STATUS_CSEL_HI:`STATUS_CSEL_LO]),
		.greater(flag_greater),
		.zero(flag_zero),
		.negative(flag_negative),
		.overflow(flag_overflow),
		.cond_out(flag_cond)
	);

	// ----------------------------------------
	// Conditional gating
	// ----------------------------------------
	wire allowed;
	wire exec;
	wire dp_we;
	wire flag_we;

	assign allowed = ~op_conditional | (op_exec_on_true == status_reg[`STATUS_COND_BIT]);
	assign exec = op_valid & allowed;
	assign dp_we = exec & dp_write;
	assign flag_we = op_valid & flag_op & ~op_conditional;

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always @* begin
		status_next = status_reg;
		if (flag_we) begin
			status_next[`STATUS_GREATER_BIT] = flag_greater;
			status_next[`STATUS_ZERO_BIT] = flag_zero;
			status_next[`STATUS_NEG_BIT] = flag_negative;
			status_next[`STATUS_OVF_BIT] = flag_overflow;
			status_next[`STATUS_COND_BIT] = flag_cond;
		end else if (sys_wr_en && sys_wr_sel == `SYS_STATUS) begin
			status_next = sys_wr_data[7:0];
		end
	end

	always @(posedge core_clk) begin
		if (!reset_n) begin
			status_reg <= `STATUS_RESET;
		end else begin
			status_reg <= status_next;
		end
	end

	assign status_word = {24'h00_0000, status_reg};
	assign cond_bit = status_reg[`STATUS_COND_BIT];

	// ----------------------------------------
	// Data register writes
	// ----------------------------------------
	integer i;

	always @(posedge core_clk) begin
		for (i = 0; i < 2; i = i + 1) begin
			if (dp_we && dst_sel == i[2:0]) begin
				if (guard_only) begin
					accum_guard[i] <= alu_result[7:0];
				end else begin
					accum_guard[i] <= alu_result[39:32];
					accum_body[i] <= alu_result[31:0];
				end
			end else if (i == 0 && sys_wr_en && sys_wr_sel == `SYS_ACCUM_FIRST) begin
				accum_guard[i] <= {8{sys_wr_data[31]}};
				accum_body[i] <= sys_wr_data;
			end
		end
		for (i = 0; i < 6; i = i + 1) begin
			if (dp_we && !is_accum(dst_sel) && opnd_index(dst_sel) == i[2:0]) begin
				opnd_reg[i] <= alu_result[31:0];
			end else if (sys_wr_en && i >= 2 && sys_wr_sel == i[2:0]) begin
				opnd_reg[i] <= sys_wr_data;
			end
		end
	end

	// ----------------------------------------
	// System register read
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!reset_n) begin
			sys_rd_data <= 32'h0000_0000;
		end else begin
			case (sys_rd_sel)
				`SYS_STATUS: sys_rd_data <= status_word;
				`SYS_ACCUM_FIRST: sys_rd_data <= accum_body[0];
				`SYS_XBUS_FIRST: sys_rd_data <= opnd_reg[2];
				`SYS_XBUS_SECOND: sys_rd_data <= opnd_reg[3];
				`SYS_YBUS_FIRST: sys_rd_data <= opnd_reg[4];
				`SYS_YBUS_SECOND: sys_rd_data <= opnd_reg[5];
				default: sys_rd_data <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Completion pulses
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (!reset_n) begin
			op_done <= 1'b0;
			op_skipped <= 1'b0;
		end else begin
			op_done <= exec;
			op_skipped <= op_valid & ~allowed;
		end
	end

endmodule

//--- bench/core_model.sv
// Core-side model issuing DSP ops and system register accesses
`timescale 1ns/10ps
module core_model (
	input wire core_clk,
	input wire [31:0] sys_rd_data,
	output reg op_valid,
	output reg [3:0] op_code,
	output reg [2:0] op_src1,
	output reg [2:0] op_src2,
	output reg [2:0] op_dst,
	output reg op_conditional,
	output reg op_exec_on_true,
	output reg [31:0] op_data,
	output reg sys_wr_en,
	output reg [2:0] sys_wr_sel,
	output reg [31:0] sys_wr_data,
	output reg [2:0] sys_rd_sel
);
	// --------------
	// Issue tasks
	// --------------
	initial begin
		{op_valid, op_code, op_src1, op_src2, op_dst, op_conditional, op_exec_on_true} = 16'h0;
		{op_data, sys_wr_en, sys_wr_sel, sys_wr_data, sys_rd_sel} = 71'h0;
	end
	task issue(input [3:0] c, input [2:0] s1, input [2:0] s2, input [2:0] d, input cn, input tr, input [31:0] v);
		begin
			@(negedge core_clk);
			{op_valid, op_code, op_src1, op_src2, op_dst, op_conditional, op_exec_on_true} = {1'b1, c, s1, s2, d, cn, tr};
			op_data = v;
			@(negedge core_clk);
			op_valid = 1'b0;
			op_data = ~op_data;
		end
	endtask
	task wr(input [2:0] sel, input [31:0] v);
		begin
			@(negedge core_clk);
			sys_wr_en = 1'b1;
			sys_wr_sel = sel;
			sys_wr_data = (sel == 3'h0) ? {24'h0, v[7:0]} : v;
			@(negedge core_clk);
			sys_wr_en = 1'b0;
			sys_wr_data = ~sys_wr_data;
		end
	endtask
	task rd(input [2:0] sel, output [31:0] q);
		begin
			@(negedge core_clk);
			sys_rd_sel = sel;
			@(negedge core_clk);
			q = sys_rd_data;
		end
	endtask
endmodule

//--- bench/dsp_rf_checker_sva.sv
// Assertion checker for the DSP register file status word
`timescale 1ns/10ps
module dsp_rf_checker (
	input wire core_clk,
	input wire reset_n,
	input wire op_valid,
	input wire [3:0] op_code,
	input wire op_conditional,
	input wire op_exec_on_true,
	input wire sys_wr_en,
	input wire [31:0] status_word,
	input wire cond_bit,
	input wire op_done,
	input wire op_skipped
);
	// --------------
	// Properties
	// --------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	property p_rsvd; status_word[31:8] == 24'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("upper status set");
	property p_rst; disable iff (1'b0) !reset_n |=> status_word == 32'h0 && !op_done && !op_skipped; endproperty
	a_rst: assert property (p_rst) else $error("reset value");
	property p_dc; cond_bit == status_word[0]; endproperty
	a_dc: assert property (p_dc) else $error("cond bit");
	property p_skip; op_valid && op_conditional && (cond_bit != op_exec_on_true) |=> op_skipped && !op_done; endproperty
	a_skip: assert property (p_skip) else $error("not skipped");
	property p_exec; op_valid && !(op_conditional && (cond_bit != op_exec_on_true)) |=> op_done && !op_skipped; endproperty
	a_exec: assert property (p_exec) else $error("not done");
	property p_cstat; op_valid && op_conditional && !sys_wr_en |=> $stable(status_word); endproperty
	a_cstat: assert property (p_cstat) else $error("cond op status");
	property p_nof; op_valid && op_code >= 4'h8 && !sys_wr_en |=> $stable(status_word); endproperty
	a_nof: assert property (p_nof) else $error("transfer status");
	property p_cs; op_valid && !sys_wr_en |=> $stable(status_word[3:1]); endproperty
	a_cs: assert property (p_cs) else $error("select changed");
	property p_excl; op_valid && !op_conditional && op_code < 4'h8 |=> !(status_word[7] && (status_word[6] || status_word[5]));
	endproperty
	a_excl: assert property (p_excl) else $error("greater flag");
	property p_clr; op_valid && !op_conditional && op_code == 4'h7 |=> status_word[7:4] == 4'h4
		&& status_word[0] == (status_word[3:1] == 3'h2 || status_word[3:1] == 3'h5); endproperty
	a_clr: assert property (p_clr) else $error("clear flags");
	c_done: cover property (op_done);
	c_skip: cover property (op_skipped);
	c_clr: cover property (op_valid && op_code == 4'h7);
endmodule
bind dsp_register_file_status dsp_rf_checker u_dsp_rf_checker (.core_clk(core_clk), .reset_n(reset_n),
	.op_valid(op_valid), .op_code(op_code), .op_conditional(op_conditional), .op_exec_on_true(op_exec_on_true),
	.sys_wr_en(sys_wr_en), .status_word(status_word), .cond_bit(cond_bit), .op_done(op_done), .op_skipped(op_skipped));

//--- bench/tb_top.sv
// Self-checking bench for the DSP register file status word
`timescale 1ns/10ps
module tb_top;
	logic core_clk = 1'b0;
	logic reset_n = 1'b0;
	wire op_valid, op_conditional, op_exec_on_true, sys_wr_en, cond_bit, op_done, op_skipped;
	wire [3:0] op_code;
	wire [2:0] op_src1, op_src2, op_dst, sys_wr_sel, sys_rd_sel;
	wire [31:0] op_data, sys_wr_data, sys_rd_data, status_word;
	logic [31:0] q;
	int n_fail = 0;
	int compares = 0;
	int k;
	always #10 core_clk = ~core_clk;
	dsp_register_file_status u_dsp_register_file_status (.*);
	core_model u_core_model (.*);
	// --------------
	// Helpers
	// --------------
	task chk(input [31:0] seen, input [31:0] exp);
		begin
			compares++;
			if (seen !== exp) begin
				n_fail++;
				$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
			end
		end
	endtask
	task op(input [3:0] c, input [2:0] s1, input [2:0] s2, input [2:0] d, input [31:0] st);
		begin
			u_core_model.issue(c, s1, s2, d, 1'b0, 1'b0, 32'h0);
			chk({op_done, op_skipped}, 2'h2);
			chk(status_word, st);
		end
	endtask
	task rdchk(input [2:0] sel, input [31:0] exp);
		begin
			u_core_model.rd(sel, q);
			chk(q, exp);
		end
	endtask
	task conclude;
		begin
			$display("compares=%0d n_fail=%0d", compares, n_fail);
			if (n_fail == 0 && compares > 0)
				$display("verification passed");
			else
				$display("verification failed");
			$finish;
		end
	endtask
	// --------------
	// Tests
	// --------------
	initial begin
		#200000;
		n_fail++;
		conclude();
	end
	initial begin
		repeat (12) @(negedge core_clk);
		reset_n = 1'b1;
		chk(status_word, 32'h0);
		rdchk(3'h0, 32'h0);
		$display("t1 done");
		u_core_model.wr(3'h0, 32'h0A);
		chk(status_word, 32'h0A);
		u_core_model.wr(3'h1, 32'h80000000);
		rdchk(3'h1, 32'h80000000);
		op(4'h3, 3'h0, 3'h0, 3'h1, 32'h2A);
		$display("t2 done");
		u_core_model.wr(3'h0, 32'h06);
		u_core_model.wr(3'h2, 32'h7FFFFFFF);
		u_core_model.wr(3'h3, 32'h1);
		op(4'h0, 3'h4, 3'h5, 3'h1, 32'h97);
		u_core_model.wr(3'h0, 32'h0);
		u_core_model.wr(3'h2, 32'h80000000);
		op(4'h0, 3'h4, 3'h4, 3'h4, 32'h31);
		rdchk(3'h2, 32'h0);
		$display("t3 done");
		for (k = 0; k < 6; k++) begin
			u_core_model.wr(3'h0, k << 1);
			op(4'h2, 3'h4, 3'h5, 3'h0, 32'h20 | (k << 1) | (k < 2));
			chk(cond_bit, k < 2);
		end
		op(4'h2, 3'h5, 3'h5, 3'h0, 32'h4B);
		$display("t4 done");
		u_core_model.issue(4'h3, 3'h5, 3'h0, 3'h6, 1'b1, 1'b1, 32'h0);
		chk({op_done, op_skipped}, 2'h2);
		chk(status_word, 32'h4B);
		u_core_model.issue(4'h3, 3'h4, 3'h0, 3'h6, 1'b1, 1'b0, 32'h0);
		chk({op_done, op_skipped}, 2'h1);
		chk(status_word, 32'h4B);
		rdchk(3'h4, 32'h1);
		$display("t5 done");
		// Transfers, multiply and the two unused codes
		for (k = 8; k < 16; k++) begin
			u_core_model.issue(k[3:0], 3'h4, 3'h5, 3'h2, 1'b0, 1'b0, 32'h12345678);
			chk(status_word, 32'h4B);
		end
		rdchk(3'h2, 32'h56780000);
		rdchk(3'h1, 32'h80000000);
		$display("t6 done");
		op(4'h2, 3'h5, 3'h4, 3'h0, 32'h2A);
		op(4'h7, 3'h0, 3'h0, 3'h1, 32'h4B);
		reset_n = 1'b0;
		repeat (2) @(negedge core_clk);
		chk(status_word, 32'h0);
		reset_n = 1'b1;
		rdchk(3'h0, 32'h0);
		$display("t7 done");
		conclude();
	end
endmodule
